// File: pcc_defines.vh
// Purpose: Constants for the PLL and clock divider control block
// Assumes: 32-bit AHB-Lite word per register, low 16 bits used
// Notes:   Offsets are chosen locally
`ifndef PCC_DEFINES_VH
`define PCC_DEFINES_VH

// ****************************************
// Register byte offsets
// ****************************************
`define PCC_OFS_MAIN_FB      8'h00
`define PCC_OFS_RC_TRIM      8'h04
`define PCC_OFS_MAIN_DIV     8'h08
`define PCC_OFS_AUX_CTRL     8'h0c
`define PCC_OFS_AUX_FB       8'h10
`define PCC_OFS_AUX_DIV      8'h14
`define PCC_OFS_CAN_CTRL     8'h18
`define PCC_OFS_REF_CTRL     8'h1c

// ****************************************
// Reset values
// ****************************************
`define PCC_RST_FB_MULT      8'h96
`define PCC_RST_POST_A       3'h4
`define PCC_RST_POST_B       3'h1
`define PCC_RST_PRESCALE     4'h1

// ****************************************
// Field positions and timing
// ****************************************
`define PCC_AUX_CONNECT_BIT  15
`define PCC_AUX_LOCKED_BIT   14
`define PCC_AUX_INSEL_BIT    8
`define PCC_CAN_ON_BIT       15
`define PCC_REF_ON_BIT       15
`define PCC_REF_IDLE_BIT     13
`define PCC_REF_PIN_BIT      12
`define PCC_REF_SLEEP_BIT    11
`define PCC_REF_SWREQ_BIT    9
`define PCC_REF_ACTIVE_BIT   8
`define PCC_LOCK_CYCLES      8'h3f
`define PCC_SWITCH_CYCLES    4'h7

`endif

// File: pcc_lock_timer.v
// Purpose: Lock status model for the auxiliary PLL
// Assumes: Lock declared after a fixed settle count
// Notes:   Any change of settings restarts the count
`timescale 1ns/1ps
`include "pcc_defines.vh"

module pcc_lock_timer (
    input  wire       hclk,      // System clock
    input  wire       hresetn,   // Async reset, active low
    input  wire       run,       // PLL running
    input  wire       restart,   // Settings changed
    output reg        locked     // Lock status
);

    reg [7:0] count;

    // ****************************************
    // Settle counter
    // ****************************************
    // Counts settle time, drops lock on restart
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count  <= 8'h00;
            locked <= 1'b0;
        end else if (!run || restart) begin
            count  <= 8'h00;
            locked <= 1'b0;
        end else if (count == `PCC_LOCK_CYCLES) begin
            locked <= 1'b1;
        end else begin
            count <= count + 8'h01;
        end
    end

endmodule

// File: pcc_clock_ctrl.v
// Purpose: Clock generation control and status registers on AHB-Lite
// Assumes: Single word transfers, OKAY response, one read wait state
// Notes:   Settings leave the block as registered control outputs
// Notes:   Lock and divider switch use fixed cycle counts
`timescale 1ns/1ps
`include "pcc_defines.vh"

module pcc_clock_ctrl (
    input  wire        hclk,              // System clock
    input  wire        hresetn,           // Async reset, active low
    input  wire        hsel,              // Slave select
    input  wire [31:0] haddr,             // Byte address
    input  wire [1:0]  htrans,            // Transfer type
    input  wire        hwrite,            // Write when high
    input  wire [2:0]  hsize,             // Transfer size
    input  wire        hready,            // Bus ready in
    input  wire [31:0] hwdata,            // Write data
    output reg  [31:0] hrdata,            // Read data
    output reg         hreadyout,         // Slave ready
    output reg         hresp,             // Always OKAY
    input  wire        aux_idle,          // Device in idle mode
    input  wire        aux_sleep,         // Device in sleep mode
    output reg  [7:0]  main_fb_multiplier, // Main PLL multiplier
    output reg  [5:0]  rc_trim_code,      // RC trim
    output reg  [2:0]  main_vco_divisor,  // Main VCO divide 1..4
    output reg  [2:0]  main_post_ratio_a, // Main post ratio a
    output reg  [2:0]  main_post_ratio_b, // Main post ratio b
    output reg         aux_pll_connect,   // Aux PLL in path
    output reg         aux_pll_input_select, // Aux input select
    output reg  [3:0]  aux_pll_prescale,  // Aux prescale code 0..15
    output reg  [7:0]  aux_fb_multiplier, // Aux PLL multiplier
    output reg  [2:0]  aux_vco_divisor,   // Aux VCO divide 1..4
    output reg  [2:0]  aux_post_ratio_a,  // Aux post ratio a
    output reg  [2:0]  aux_post_ratio_b,  // Aux post ratio b
    output reg         can_clk_gen_on,    // CAN clock running
    output reg  [3:0]  can_clk_source,    // CAN source, 0 when none
    output reg  [7:0]  can_divide_by,     // CAN divide 1..128
    output reg         refout_pin_drive,  // Reference output running
    output reg  [3:0]  refout_source      // Reference source select
);

    // Local state
    reg        dph_valid;
    reg        dph_write;
    reg [7:0]  dph_addr;
    reg [1:0]  main_vco_tap_select;
    reg [1:0]  aux_vco_tap_select;
    reg [3:0]  can_sel_reg;
    reg [6:0]  can_clk_divisor;
    reg        refout_on;
    reg        refout_idle_stop;
    reg        refout_pin_en;
    reg        refout_sleep_run;
    reg        refout_div_switch_req;
    reg        refout_active_flag;
    reg [3:0]  refout_sel_reg;
    reg [3:0]  switch_count;
    reg        aux_restart;
    reg [15:0] next_rdata;
    wire       aux_pll_locked;
    wire       addr_ok;
    wire       wr_en;
    wire       ref_want;

    // ****************************************
    // AHB-Lite address phase
    // ****************************************
    // Capture a valid address phase for the data phase
    // Held through a read wait state, so the read mux
    // still sees the address that was accepted
    // Address bits above 7 are not decoded, so the map repeats
    assign addr_ok = hsel && hready && htrans[1];
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dph_valid <= 1'b0;
            dph_write <= 1'b0;
            dph_addr  <= 8'h00;
        end else if (hready) begin
            dph_valid <= addr_ok;
            dph_write <= hwrite;
            dph_addr  <= haddr[7:0];
        end
    end

    // Write lands at the end of its data phase
    // Writes never stall, so the strobe lasts one cycle
    assign wr_en = dph_valid && dph_write && hready;

    // One wait state after each read address phase
    // The read mux then works from registers that a write
    // in the previous data phase has already updated
    // Response is always OKAY
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= !(addr_ok && !hwrite);
            hresp     <= 1'b0;
        end
    end

    // ****************************************
    // Register writes
    // ****************************************
    // Field layout, low half word of each register:
    //   main fb   [7:0] multiplier
    //   rc trim   [5:0] trim code
    //   main div  [9:8] VCO tap, [6:4] ratio a, [2:0] ratio b
    //   aux ctrl  [15] connect, [14] locked, [8] input, [3:0] prescale
    //   aux fb    [7:0] multiplier
    //   aux div   same layout as main div
    //   CAN       [15] on, [11:8] source, [6:0] divisor
    //   ref low   [15] on, [13] idle stop, [12] pin, [11] sleep run,
    //             [9] switch request, [8] active, [3:0] source
    // Reserved bits 11 to 8 of the feedback registers are not
    // stored, so they read back zero whatever software writes
    // Read-only status bits ignore writes
    // Only implemented fields are stored
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            main_fb_multiplier   <= `PCC_RST_FB_MULT;
            rc_trim_code         <= 6'h00;
            main_vco_tap_select  <= 2'h0;
            main_post_ratio_a    <= `PCC_RST_POST_A;
            main_post_ratio_b    <= `PCC_RST_POST_B;
            aux_pll_connect      <= 1'b0;
            aux_pll_input_select <= 1'b0;
            aux_pll_prescale     <= `PCC_RST_PRESCALE;
            aux_fb_multiplier    <= `PCC_RST_FB_MULT;
            aux_vco_tap_select   <= 2'h0;
            aux_post_ratio_a     <= `PCC_RST_POST_A;
            aux_post_ratio_b     <= `PCC_RST_POST_B;
            can_clk_gen_on       <= 1'b0;
            can_sel_reg          <= 4'h0;
            can_clk_divisor      <= 7'h00;
            refout_on            <= 1'b0;
            refout_idle_stop     <= 1'b0;
            refout_pin_en        <= 1'b0;
            refout_sleep_run     <= 1'b0;
            refout_sel_reg       <= 4'h0;
            aux_restart          <= 1'b0;
        end else begin
            aux_restart <= 1'b0;
            if (wr_en) begin
                case (dph_addr)
                    `PCC_OFS_MAIN_FB: begin
                        main_fb_multiplier <= hwdata[7:0];
                    end
                    `PCC_OFS_RC_TRIM: begin
                        rc_trim_code <= hwdata[5:0];
                    end
                    `PCC_OFS_MAIN_DIV: begin
                        main_vco_tap_select <= hwdata[9:8];
                        main_post_ratio_a   <= hwdata[6:4];
                        main_post_ratio_b   <= hwdata[2:0];
                    end
                    `PCC_OFS_AUX_CTRL: begin
                        aux_pll_connect <= hwdata[`PCC_AUX_CONNECT_BIT];
                        aux_pll_input_select <=
                            hwdata[`PCC_AUX_INSEL_BIT];
                        aux_pll_prescale <= hwdata[3:0];
                        aux_restart      <= 1'b1;
                    end
                    `PCC_OFS_AUX_FB: begin
                        aux_fb_multiplier <= hwdata[7:0];
                        aux_restart       <= 1'b1;
                    end
                    `PCC_OFS_AUX_DIV: begin
                        aux_vco_tap_select <= hwdata[9:8];
                        aux_post_ratio_a   <= hwdata[6:4];
                        aux_post_ratio_b   <= hwdata[2:0];
                    end
                    `PCC_OFS_CAN_CTRL: begin
                        can_clk_gen_on  <= hwdata[`PCC_CAN_ON_BIT];
                        can_sel_reg     <= hwdata[11:8];
                        can_clk_divisor <= hwdata[6:0];
                    end
                    `PCC_OFS_REF_CTRL: begin
                        refout_on        <= hwdata[`PCC_REF_ON_BIT];
                        refout_idle_stop <= hwdata[`PCC_REF_IDLE_BIT];
                        refout_pin_en    <= hwdata[`PCC_REF_PIN_BIT];
                        refout_sleep_run <= hwdata[`PCC_REF_SLEEP_BIT];
                        refout_sel_reg   <= hwdata[3:0];
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // ****************************************
    // Auxiliary PLL lock tracking
    // ****************************************
    // Lock model restarts when settings change
    // Any write to aux control or aux feedback drops lock
    // Clearing the connect bit also drops lock at once
    // Lock is a timed model, not a phase detector
    pcc_lock_timer u_lock (
        .hclk    (hclk),
        .hresetn (hresetn),
        .run     (aux_pll_connect),
        .restart (aux_restart),
        .locked  (aux_pll_locked)
    );

    // ****************************************
    // Reference output and divider switch
    // ****************************************
    // Run unless disabled, or stopped by idle or sleep
    // Idle stops the output only with idle stop set
    // Sleep stops it unless sleep run is set
    assign ref_want = refout_on &&
                      !(aux_idle && refout_idle_stop) &&
                      !(aux_sleep && !refout_sleep_run);

    // Switch request held until countdown ends; set wins
    // A new request while one is pending restarts the count
    // Writing zero to the request bit has no effect
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            refout_div_switch_req <= 1'b0;
            switch_count          <= 4'h0;
        end else if (wr_en && dph_addr == `PCC_OFS_REF_CTRL &&
                     hwdata[`PCC_REF_SWREQ_BIT]) begin
            refout_div_switch_req <= 1'b1;
            switch_count          <= `PCC_SWITCH_CYCLES;
        end else if (refout_div_switch_req) begin
            if (switch_count == 4'h0) begin
                refout_div_switch_req <= 1'b0;
            end else begin
                switch_count <= switch_count - 4'h1;
            end
        end
    end

    // Active flag trails the output until it has stopped
    // Flag falls two cycles after the output is disabled
    // Source and divider are safe to change once it is low
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            refout_pin_drive   <= 1'b0;
            refout_active_flag <= 1'b0;
            refout_source      <= 4'h0;
        end else begin
            refout_pin_drive   <= ref_want && refout_pin_en;
            refout_active_flag <= ref_want || refout_pin_drive;
            refout_source      <= refout_sel_reg;
        end
    end

    // ****************************************
    // Decoded clock selections
    // ****************************************
    // VCO tap code to divide ratio, CAN gating and divisor
    // Each decoded output lags its field by one cycle
    // Tap code zero is the slowest tap, divide by 4
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            main_vco_divisor <= 3'h4;
            aux_vco_divisor  <= 3'h4;
            can_clk_source   <= 4'h0;
            can_divide_by    <= 8'h01;
        end else begin
            main_vco_divisor <= 3'h4 - {1'b0, main_vco_tap_select};
            aux_vco_divisor  <= 3'h4 - {1'b0, aux_vco_tap_select};
            // Reserved codes above 1010 give no clock
            if (can_clk_gen_on && can_sel_reg <= 4'ha) begin
                can_clk_source <= can_sel_reg;
            end else begin
                can_clk_source <= 4'h0;
            end
            can_divide_by <= {1'b0, can_clk_divisor} + 8'h01;
        end
    end

    // ****************************************
    // Read mux
    // ****************************************
    // Unimplemented and reserved bits read zero
    // Mux works from the captured data phase address
    // Locked, request and active are live status bits
    always @* begin
        next_rdata = 16'h0000;
        case (dph_addr)
            `PCC_OFS_MAIN_FB:  next_rdata = {8'h00, main_fb_multiplier};
            `PCC_OFS_RC_TRIM:  next_rdata = {10'h000, rc_trim_code};
            `PCC_OFS_MAIN_DIV: next_rdata = {6'h00, main_vco_tap_select,
                                   1'b0, main_post_ratio_a,
                                   1'b0, main_post_ratio_b};
            `PCC_OFS_AUX_CTRL: next_rdata = {aux_pll_connect,
                                   aux_pll_locked, 5'h00,
                                   aux_pll_input_select, 4'h0,
                                   aux_pll_prescale};
            `PCC_OFS_AUX_FB:   next_rdata = {8'h00, aux_fb_multiplier};
            `PCC_OFS_AUX_DIV:  next_rdata = {6'h00, aux_vco_tap_select,
                                   1'b0, aux_post_ratio_a,
                                   1'b0, aux_post_ratio_b};
            `PCC_OFS_CAN_CTRL: next_rdata = {can_clk_gen_on, 3'h0,
                                   can_sel_reg, 1'b0, can_clk_divisor};
            `PCC_OFS_REF_CTRL: next_rdata = {refout_on, 1'b0,
                                   refout_idle_stop, refout_pin_en,
                                   refout_sleep_run, 1'b0,
                                   refout_div_switch_req,
                                   refout_active_flag, 4'h0,
                                   refout_sel_reg};
            default:           next_rdata = 16'h0000;
        endcase
    end

    // Read data loaded at the end of the wait state
    // Cleared when a read is accepted, so stale data
    // from an earlier read never stands in a new one
    // Upper half always reads zero
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h00000000;
        end else if (addr_ok && !hwrite) begin
            hrdata <= 32'h00000000;
        end else if (dph_valid && !dph_write && !hreadyout) begin
            hrdata <= {16'h0000, next_rdata};
        end
    end

endmodule

// File: pcc_clock_ctrl_asserts.sv
// Purpose: Bus and field checks for the clock control block
// Assumes: Zero wait state writes, field visible after data phase
// Notes:   Bound to every instance of the register block
`timescale 1ns/1ps

// ****************************************
// Checker
// ****************************************
module pcc_clock_ctrl_asserts (
    input wire        hclk,               // System clock
    input wire        hresetn,            // Async reset, active low
    input wire        hsel,               // Slave select
    input wire [31:0] haddr,              // Byte address
    input wire [1:0]  htrans,             // Transfer type
    input wire        hwrite,             // Write when high
    input wire        hready,             // Bus ready in
    input wire [31:0] hwdata,             // Write data
    input wire [7:0]  main_fb_multiplier, // Main multiplier
    input wire [5:0]  rc_trim_code,       // RC trim
    input wire [2:0]  main_vco_divisor,   // Main VCO divide
    input wire [2:0]  main_post_ratio_a,  // Main post ratio a
    input wire [2:0]  main_post_ratio_b,  // Main post ratio b
    input wire [7:0]  aux_fb_multiplier,  // Aux multiplier
    input wire [2:0]  aux_post_ratio_a,   // Aux post ratio a
    input wire [2:0]  aux_post_ratio_b,   // Aux post ratio b
    input wire        can_clk_gen_on,     // CAN clock running
    input wire [3:0]  can_clk_source,     // CAN source
    input wire [7:0]  can_divide_by       // CAN divide
);
    reg       wr_pend; // Write in data phase
    reg [7:0] wr_ofs;  // Offset of that write

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // Track the write data phase
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            wr_ofs  <= 8'h00;
        end else if (hready) begin
            wr_pend <= hsel & htrans[1] & hwrite;
            wr_ofs  <= haddr[7:0];
        end
    end

    chk_rst_values: assert property (
        $rose(hresetn) |-> main_post_ratio_a == 3'h4 &&
        main_post_ratio_b == 3'h1 && aux_post_ratio_a == 3'h4 &&
        aux_post_ratio_b == 3'h1 && aux_fb_multiplier == 8'h96 &&
        main_fb_multiplier == 8'h96) else $error("bad reset value");
    chk_main_fb_store: assert property (
        wr_pend && hready && wr_ofs == 8'h00
        |=> main_fb_multiplier == $past(hwdata[7:0]))
        else $error("main multiplier not stored");
    chk_trim_store: assert property (
        wr_pend && hready && wr_ofs == 8'h04
        |=> rc_trim_code == $past(hwdata[5:0]))
        else $error("trim not stored");
    chk_aux_fb_store: assert property (
        wr_pend && hready && wr_ofs == 8'h10
        |=> aux_fb_multiplier == $past(hwdata[7:0]))
        else $error("aux multiplier not stored");
    chk_post_store: assert property (
        wr_pend && hready && wr_ofs == 8'h08
        |=> main_post_ratio_a == $past(hwdata[6:4]) &&
        main_post_ratio_b == $past(hwdata[2:0]))
        else $error("post ratios not stored");
    chk_fb_hold: assert property (
        !(wr_pend && hready) |=> $stable(main_fb_multiplier))
        else $error("multiplier changed without write");
    chk_vco_range: assert property (
        main_vco_divisor != 3'h0 && main_vco_divisor <= 3'h4)
        else $error("vco divisor out of range");
    chk_can_off_none: assert property (
        !can_clk_gen_on ##1 !can_clk_gen_on |-> can_clk_source == 4'h0)
        else $error("CAN source while disabled");
    chk_can_src_range: assert property (
        can_clk_source <= 4'ha) else $error("reserved CAN source out");
    chk_can_div_min: assert property (
        can_divide_by != 8'h00) else $error("CAN divide by zero");

    cover property (wr_pend && hready && wr_ofs == 8'h18);
    cover property (can_clk_gen_on && can_clk_source == 4'h9);
    cover property (can_divide_by == 8'h80);
endmodule

bind pcc_clock_ctrl pcc_clock_ctrl_asserts u_pcc_clock_ctrl_asserts (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready, .hwdata,
    .main_fb_multiplier, .rc_trim_code, .main_vco_divisor,
    .main_post_ratio_a, .main_post_ratio_b, .aux_fb_multiplier,
    .aux_post_ratio_a, .aux_post_ratio_b, .can_clk_gen_on,
    .can_clk_source, .can_divide_by);

// File: pll_and_clock_divider_control_bench.sv
// Purpose: Self-checking bench for the clock control registers
// Assumes: Read data taken at the edge that ends the data phase
// Notes:   Bench acts as the only AHB-Lite master
`timescale 1ns/1ps

// ****************************************
// Bench
// ****************************************
module pll_and_clock_divider_control_bench;
    logic hclk, hresetn, hsel, hwrite, aux_idle, aux_sleep;
    logic [31:0] haddr, hwdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    wire [31:0] hrdata;
    wire hreadyout, hresp, aux_pll_connect, aux_pll_input_select;
    wire can_clk_gen_on, refout_pin_drive;
    wire [7:0] main_fb_multiplier, aux_fb_multiplier, can_divide_by;
    wire [5:0] rc_trim_code;
    wire [2:0] main_vco_divisor, main_post_ratio_a, main_post_ratio_b;
    wire [2:0] aux_vco_divisor, aux_post_ratio_a, aux_post_ratio_b;
    wire [3:0] aux_pll_prescale, can_clk_source, refout_source;
    integer num_errors, total_checks, i;
    logic [31:0] rd_q;
    logic [31:0] pat [0:6] = '{32'hfffff0c8, 32'hffffffdf, 32'hffffff77,
        32'hffffffc8, 32'hfffff010, 32'hffffff77, 32'hffffffff};
    logic [31:0] msk [0:6] = '{32'h00c8, 32'h001f, 32'h0377, 32'h8108,
        32'h0010, 32'h0377, 32'h8f7f};

    pcc_clock_ctrl u_pcc_clock_ctrl (
        .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
        .hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp,
        .aux_idle, .aux_sleep, .main_fb_multiplier, .rc_trim_code,
        .main_vco_divisor, .main_post_ratio_a, .main_post_ratio_b,
        .aux_pll_connect, .aux_pll_input_select, .aux_pll_prescale,
        .aux_fb_multiplier, .aux_vco_divisor, .aux_post_ratio_a,
        .aux_post_ratio_b, .can_clk_gen_on, .can_clk_source,
        .can_divide_by, .refout_pin_drive, .refout_source);

    // Clock and watchdog
    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    initial begin
        #200000;
        num_errors = num_errors + 1;
        tally_and_finish;
    end

    task tally_and_finish;
        begin
            if (num_errors == 0 && total_checks > 0)
                $display("ALL TESTS PASSED");
            else
                $display("TESTS FAILED");
            $finish;
        end
    endtask

    task chk(input [31:0] got, input [31:0] exp);
        begin
            total_checks = total_checks + 1;
            if (got !== exp) begin
                num_errors = num_errors + 1;
                $display("wrong value at %0t: %h not %h", $time, got, exp);
            end
        end
    endtask

    // Address phase held until hready, then data phase
    task bus(input [31:0] a, input w, input [31:0] d);
        begin
            @(posedge hclk);
            hsel <= 1'b1;
            haddr <= a;
            htrans <= 2'b10;
            hwrite <= w;
            @(posedge hclk);
            while (hreadyout !== 1'b1) @(posedge hclk);
            hsel <= 1'b0;
            htrans <= 2'b00;
            hwdata <= d;
            @(posedge hclk);
            while (hreadyout !== 1'b1) @(posedge hclk);
            rd_q = hrdata;
        end
    endtask

    task wr(input [31:0] a, input [31:0] d);
        bus(a, 1'b1, d);
    endtask

    task rd_chk(input [31:0] a, input [31:0] exp);
        begin
            bus(a, 1'b0, 32'h0);
            chk(rd_q, exp);
        end
    endtask

    task settle(input integer n);
        begin
            repeat (n) @(posedge hclk);
            #1;
        end
    endtask

    task test_reset_values;
        begin
            rd_chk(32'h00, 32'h0096);
            rd_chk(32'h04, 32'h0000);
            rd_chk(32'h08, 32'h0041);
            rd_chk(32'h0c, 32'h0001);
            rd_chk(32'h10, 32'h0096);
            rd_chk(32'h14, 32'h0041);
            rd_chk(32'h18, 32'h0000);
            rd_chk(32'h1c, 32'h0000);
            chk({29'h0, main_vco_divisor}, 32'h4);
            chk({24'h0, can_divide_by}, 32'h1);
        end
    endtask

    task test_write_masks;
        begin
            // Descending offsets write aux div before aux control, so aux ratios never change while connected
            for (i = 6; i >= 0; i = i - 1)
                wr(4 * i, pat[i]);
            for (i = 0; i < 7; i = i + 1)
                rd_chk(4 * i, msk[i]);
            wr(32'h20, 32'hffffffff);
            rd_chk(32'h20, 32'h0);
            chk({26'h0, rc_trim_code}, 32'h1f);
            chk({29'h0, main_vco_divisor}, 32'h1);
            chk({24'h0, can_divide_by}, 32'h80);
            chk({28'h0, can_clk_source}, 32'h0);
            chk({28'h0, aux_pll_prescale}, 32'h8);
            chk({31'h0, aux_pll_connect}, 32'h1);
            chk({31'h0, aux_pll_input_select}, 32'h1);
            chk({24'h0, main_fb_multiplier}, 32'hc8);
            chk({24'h0, aux_fb_multiplier}, 32'h10);
            chk({29'h0, main_post_ratio_a}, 32'h7);
            chk({29'h0, main_post_ratio_b}, 32'h7);
            chk({29'h0, aux_post_ratio_a}, 32'h7);
            chk({29'h0, aux_post_ratio_b}, 32'h7);
            chk({31'h0, hresp}, 32'h0);
        end
    endtask

    task test_vco_taps;
        begin
            for (i = 0; i < 4; i = i + 1) begin
                wr(32'h08, (i << 8) | 32'h77);
                wr(32'h14, (i << 8) | 32'h77);
                settle(2);
                chk({29'h0, main_vco_divisor}, 4 - i);
                chk({29'h0, aux_vco_divisor}, 4 - i);
            end
        end
    endtask

    task test_can_sources;
        begin
            for (i = 0; i < 16; i = i + 1) begin
                wr(32'h18, 32'h807f | (i << 8));
                settle(2);
                chk({28'h0, can_clk_source}, i <= 10 ? i : 0);
            end
            wr(32'h18, 32'h097f);
            settle(2);
            chk({28'h0, can_clk_source}, 32'h0);
            chk({24'h0, can_divide_by}, 32'h80);
        end
    endtask

    task test_aux_lock;
        begin
            wr(32'h0c, 32'h8001);
            rd_chk(32'h0c, 32'h8001);
            settle(70);
            rd_chk(32'h0c, 32'hc001);
            wr(32'h10, 32'h0096);
            rd_chk(32'h0c, 32'h8001);
            wr(32'h0c, 32'h0001);
        end
    endtask

    task test_refout;
        begin
            wr(32'h1c, 32'h9005);
            settle(2);
            chk({31'h0, refout_pin_drive}, 32'h1);
            chk({28'h0, refout_source}, 32'h5);
            rd_chk(32'h1c, 32'h9105);
            wr(32'h1c, 32'h9205);
            rd_chk(32'h1c, 32'h9305);
            settle(12);
            rd_chk(32'h1c, 32'h9105);
            wr(32'h1c, 32'hb005);
            aux_idle <= 1'b1;
            settle(3);
            chk({31'h0, refout_pin_drive}, 32'h0);
            wr(32'h1c, 32'h9005);
            aux_idle <= 1'b0;
            aux_sleep <= 1'b1;
            settle(3);
            chk({31'h0, refout_pin_drive}, 32'h0);
            wr(32'h1c, 32'h9805);
            settle(3);
            chk({31'h0, refout_pin_drive}, 32'h1);
            aux_sleep <= 1'b0;
            wr(32'h1c, 32'h0005);
            settle(4);
            rd_chk(32'h1c, 32'h0005);
        end
    endtask

    // Main sequence
    initial begin
        num_errors = 0;
        total_checks = 0;
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        aux_idle = 1'b0;
        aux_sleep = 1'b0;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        test_reset_values;
        test_write_masks;
        test_vco_taps;
        test_can_sources;
        test_aux_lock;
        test_refout;
        tally_and_finish;
    end
endmodule
